// *** gpiod_regs.vh ***
`ifndef GPIOD_REGS_VH
`define GPIOD_REGS_VH

// register byte offsets
`define GPIOD_OFS_CTRL       4'h0
`define GPIOD_OFS_STATUS     4'h4
`define GPIOD_CTRL_RST       15'h0000

// control fields
`define GPIOD_CTRL_MODE_LSB  0
`define GPIOD_CTRL_MODE_MSB  2
`define GPIOD_CTRL_IN_REG    3
`define GPIOD_CTRL_IN_NEG    4
`define GPIOD_CTRL_OUT_REG   5
`define GPIOD_CTRL_OUT_NEG   6
`define GPIOD_CTRL_OUT_INV   7
`define GPIOD_CTRL_OE_REG    8
`define GPIOD_CTRL_DOUBLE_DATA_IO      9
`define GPIOD_CTRL_DMODE_LSB 10
`define GPIOD_CTRL_DMODE_MSB 11
`define GPIOD_CTRL_SERDES    12
`define GPIOD_CTRL_PULL_DN   13
`define GPIOD_CTRL_USER      14
`define GPIOD_CTRL_WIDTH     15

// pin modes
`define GPIOD_MODE_UNUSED    3'h0
`define GPIOD_MODE_INPUT     3'h1
`define GPIOD_MODE_OUTPUT    3'h2
`define GPIOD_MODE_BIDIR     3'h3
`define GPIOD_MODE_CLKOUT    3'h4

// double-data variants
`define GPIOD_DD_NORMAL      2'h0
`define GPIOD_DD_RESYNC      2'h1
`define GPIOD_DD_PIPE        2'h2

// serdes
`define GPIOD_SER_LAST       2'h3
`define GPIOD_SER_FIRST      2'h0

`endif

// *** gpiod_io_cell.v ***
`timescale 1ns/1ps
`include "gpiod_regs.vh"

module gpiod_io_cell #(
  parameter HS_CELL = 1
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // core fabric side
  input  wire [3:0]  core_out,
  input  wire        core_oe,
  output reg  [3:0]  core_in,
  output wire        alternate_input_path,
  output wire        core_word_tick,
  // pad side
  input  wire        pad_i,
  output reg         pad_o,
  output wire        pad_oe,
  output wire        pad_pull_up,
  output wire        pad_pull_down
);

////////////////////////////////////////////////////////////////////////////////
// configuration registers

reg  [`GPIOD_CTRL_WIDTH-1:0] ctrl_ff;
reg                          ack_ff;
reg  [31:0]                  rdata_ff;
reg  [`GPIOD_CTRL_WIDTH-1:0] nxt_ctrl;
reg                          nxt_ack;
reg  [31:0]                  nxt_rdata;
wire                         req;
wire                         take;
wire [31:0]                  status;

assign req             = avs_read | avs_write;
// one wait cycle so read data comes from a flop
assign avs_waitrequest = req & ~ack_ff;
assign take            = req & ack_ff;

// read data is fetched in the wait cycle and held until the next read
always @* begin
  nxt_ack   = req & ~ack_ff;
  nxt_rdata = rdata_ff;
  nxt_ctrl  = ctrl_ff;
  if (avs_read & ~ack_ff) begin
    case (avs_address)
      `GPIOD_OFS_CTRL:   nxt_rdata = {17'h00000, ctrl_ff};
      `GPIOD_OFS_STATUS: nxt_rdata = status;
      default:           nxt_rdata = 32'h00000000;
    endcase
  end
  // a write lands only at the edge that completes it
  if (avs_write & take & (avs_address == `GPIOD_OFS_CTRL)) begin
    nxt_ctrl = avs_writedata[`GPIOD_CTRL_WIDTH-1:0];
  end
end

always @(posedge core_clk or negedge resetn) begin
  if (!resetn) begin
    ack_ff   <= 1'b0;
    rdata_ff <= 32'h00000000;
    ctrl_ff  <= `GPIOD_CTRL_RST;
  end else begin
    ack_ff   <= nxt_ack;
    rdata_ff <= nxt_rdata;
    ctrl_ff  <= nxt_ctrl;
  end
end

always @* begin
  avs_readdata = rdata_ff;
end

wire [2:0] mode     = ctrl_ff[`GPIOD_CTRL_MODE_MSB:`GPIOD_CTRL_MODE_LSB];
wire [1:0] dd_mode  = ctrl_ff[`GPIOD_CTRL_DMODE_MSB:`GPIOD_CTRL_DMODE_LSB];
wire       in_reg   = ctrl_ff[`GPIOD_CTRL_IN_REG];
wire       in_neg   = ctrl_ff[`GPIOD_CTRL_IN_NEG];
wire       out_reg  = ctrl_ff[`GPIOD_CTRL_OUT_REG];
wire       out_neg  = ctrl_ff[`GPIOD_CTRL_OUT_NEG];
wire       out_inv  = ctrl_ff[`GPIOD_CTRL_OUT_INV];
wire       oe_reg   = ctrl_ff[`GPIOD_CTRL_OE_REG];
wire       double_data_io     = ctrl_ff[`GPIOD_CTRL_DOUBLE_DATA_IO];
wire       pull_dn  = ctrl_ff[`GPIOD_CTRL_PULL_DN];
wire       user     = ctrl_ff[`GPIOD_CTRL_USER];
// serdes exists only on high-speed cells and excludes double_data_io
wire       serdes   = ctrl_ff[`GPIOD_CTRL_SERDES] & (HS_CELL != 0) & ~double_data_io;

wire in_act  = (mode == `GPIOD_MODE_INPUT)  | (mode == `GPIOD_MODE_BIDIR);
wire out_act = (mode == `GPIOD_MODE_OUTPUT) | (mode == `GPIOD_MODE_BIDIR);
wire clk_act = (mode == `GPIOD_MODE_CLKOUT);

////////////////////////////////////////////////////////////////////////////////
// pad synchronisers, one chain per edge

wire pad_rise_sync;
wire pad_fall_sync;

gpiod_sync2 #(
  .FALL_EDGE (0)
) u_sync_rise (
  .core_clk   (core_clk),
  .resetn     (resetn),
  .pin_level  (pad_i),
  .safe_level (pad_rise_sync)
);

gpiod_sync2 #(
  .FALL_EDGE (1)
) u_sync_fall (
  .core_clk   (core_clk),
  .resetn     (resetn),
  .pin_level  (pad_i),
  .safe_level (pad_fall_sync)
);

// bypasses every register, feeds the alternate function directly
assign alternate_input_path = pad_i;

////////////////////////////////////////////////////////////////////////////////
// input registers

reg in_rise_ff;
reg in_fall_ff;
reg in_fall_rs_ff;
reg in_pipe0_ff;
reg in_pipe1_ff;
reg [3:0] des_sh_ff;
reg [3:0] des_word_ff;
reg [1:0] ser_cnt_ff;
reg [3:0] nxt_des_sh;
reg [3:0] nxt_des_word;

// shift right so the oldest bit lands on bit0
always @* begin
  nxt_des_sh   = {pad_rise_sync, des_sh_ff[3:1]};
  nxt_des_word = des_word_ff;
  if (ser_cnt_ff == `GPIOD_SER_LAST) begin
    nxt_des_word = nxt_des_sh;
  end
end

always @(posedge core_clk or negedge resetn) begin
  if (!resetn) begin
    in_rise_ff    <= 1'b0;
    in_fall_rs_ff <= 1'b0;
    in_pipe0_ff   <= 1'b0;
    in_pipe1_ff   <= 1'b0;
    des_sh_ff     <= 4'h0;
    des_word_ff   <= 4'h0;
  end else begin
    in_rise_ff    <= pad_rise_sync;
    // fall sample moved to the rising edge, half a cycle later
    in_fall_rs_ff <= in_fall_ff;
    in_pipe0_ff   <= in_rise_ff;
    in_pipe1_ff   <= in_fall_rs_ff;
    des_sh_ff     <= nxt_des_sh;
    des_word_ff   <= nxt_des_word;
  end
end

always @(negedge core_clk or negedge resetn) begin
  if (!resetn) begin
    in_fall_ff <= 1'b0;
  end else begin
    in_fall_ff <= pad_fall_sync;
  end
end

// input is sampled whatever the driver does
always @* begin
  core_in = 4'h0;
  if (in_act) begin
    if (serdes) begin
      core_in = des_word_ff;
    end else if (double_data_io) begin
      case (dd_mode)
        `GPIOD_DD_NORMAL: core_in = {2'h0, in_fall_ff, in_rise_ff};
        `GPIOD_DD_RESYNC: core_in = {2'h0, in_fall_rs_ff, in_rise_ff};
        `GPIOD_DD_PIPE:   core_in = {2'h0, in_pipe1_ff, in_pipe0_ff};
        default:          core_in = {2'h0, in_fall_ff, in_rise_ff};
      endcase
    end else if (in_reg) begin
      core_in = {3'h0, (in_neg ? in_fall_ff : in_rise_ff)};
    end else begin
      core_in = {3'h0, pad_rise_sync};
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// output and output-enable registers

reg       out_rise_ff;
reg       out_fall_ff;
reg       oe_rise_ff;
reg       oe_fall_ff;
reg       dd_r_ff;
reg       dd_f_ff;
reg       rs0_ff;
reg       rs1_ff;
reg       rs1_n_ff;
reg       pp0_ff;
reg       pp1_ff;
reg       pp1_n_ff;
reg [3:0] ser_sh_ff;

assign core_word_tick = serdes & (ser_cnt_ff == `GPIOD_SER_FIRST);

reg [1:0] nxt_ser_cnt;
reg [3:0] nxt_ser_sh;

// serializer and deserializer share one word counter
always @* begin
  // counter parks at zero so the first word starts cleanly
  nxt_ser_cnt = serdes ? ser_cnt_ff + 2'h1 : `GPIOD_SER_FIRST;
  if (core_word_tick) begin
    nxt_ser_sh = core_out;
  end else begin
    nxt_ser_sh = {1'b0, ser_sh_ff[3:1]};
  end
end

always @(posedge core_clk or negedge resetn) begin
  if (!resetn) begin
    out_rise_ff <= 1'b0;
    oe_rise_ff  <= 1'b0;
    dd_r_ff     <= 1'b0;
    rs0_ff      <= 1'b0;
    rs1_ff      <= 1'b0;
    pp0_ff      <= 1'b0;
    pp1_ff      <= 1'b0;
    ser_sh_ff   <= 4'h0;
    ser_cnt_ff  <= 2'h0;
  end else begin
    out_rise_ff <= core_out[0];
    oe_rise_ff  <= core_oe;
    dd_r_ff     <= core_out[0];
    // both bits taken on the rising edge
    rs0_ff      <= core_out[0];
    rs1_ff      <= core_out[1];
    pp0_ff      <= rs0_ff;
    pp1_ff      <= rs1_ff;
    ser_cnt_ff  <= nxt_ser_cnt;
    ser_sh_ff   <= nxt_ser_sh;
  end
end

always @(negedge core_clk or negedge resetn) begin
  if (!resetn) begin
    out_fall_ff <= 1'b0;
    oe_fall_ff  <= 1'b0;
    dd_f_ff     <= 1'b0;
    rs1_n_ff    <= 1'b0;
    pp1_n_ff    <= 1'b0;
  end else begin
    out_fall_ff <= core_out[0];
    oe_fall_ff  <= core_oe;
    dd_f_ff     <= core_out[1];
    rs1_n_ff    <= rs1_ff;
    pp1_n_ff    <= pp1_ff;
  end
end

wire out_regd = (out_neg ? out_fall_ff : out_rise_ff) ^ out_inv;
wire oe_val   = oe_reg ? (out_neg ? oe_fall_ff : oe_rise_ff) : core_oe;

// high phase shows the rise bit, low phase the fall bit
always @* begin
  pad_o = 1'b0;
  if (clk_act) begin
    pad_o = core_clk;
  end else if (out_act) begin
    if (serdes) begin
      pad_o = ser_sh_ff[0];
    end else if (double_data_io) begin
      case (dd_mode)
        `GPIOD_DD_NORMAL: pad_o = core_clk ? dd_r_ff : dd_f_ff;
        `GPIOD_DD_RESYNC: pad_o = core_clk ? rs0_ff : rs1_n_ff;
        `GPIOD_DD_PIPE:   pad_o = core_clk ? pp0_ff : pp1_n_ff;
        default:          pad_o = core_clk ? dd_r_ff : dd_f_ff;
      endcase
    end else if (out_reg) begin
      pad_o = out_regd;
    end else begin
      pad_o = core_out[0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// driver enable and weak pulls

reg oe_drive;
reg pull_up_req;
reg pull_dn_req;

// output mode drives always, bidir follows the enable path
always @* begin
  oe_drive    = 1'b0;
  pull_up_req = 1'b1;
  pull_dn_req = 1'b0;
  // until software enters user mode the pin only pulls up
  if (user) begin
    pull_up_req = 1'b0;
    case (mode)
      `GPIOD_MODE_UNUSED: begin
        // tristated, weak pull chosen by software
        pull_up_req = ~pull_dn;
        pull_dn_req = pull_dn;
      end
      `GPIOD_MODE_OUTPUT: oe_drive = 1'b1;
      `GPIOD_MODE_BIDIR:  oe_drive = oe_val;
      `GPIOD_MODE_CLKOUT: oe_drive = 1'b1;
      default:            oe_drive = 1'b0;
    endcase
  end
end

assign pad_oe        = oe_drive;
assign pad_pull_up   = pull_up_req;
assign pad_pull_down = pull_dn_req;

assign status = {24'h000000, serdes, (HS_CELL != 0), core_in, pad_oe, pad_rise_sync};

endmodule // gpiod_io_cell

////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser, sampling edge chosen by parameter

module gpiod_sync2 #(
  parameter FALL_EDGE = 0
) (
  // clock and reset
  input  wire core_clk,
  input  wire resetn,
  // asynchronous level and its settled copy
  input  wire pin_level,
  output wire safe_level
);

reg stage1_ff;
reg stage2_ff;

// only the second stage is read, the first may be metastable
assign safe_level = stage2_ff;

generate
  if (FALL_EDGE != 0) begin : g_fall
    always @(negedge core_clk or negedge resetn) begin
      if (!resetn) begin
        stage1_ff <= 1'b0;
        stage2_ff <= 1'b0;
      end else begin
        stage1_ff <= pin_level;
        stage2_ff <= stage1_ff;
      end
    end
  end else begin : g_rise
    always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        stage1_ff <= 1'b0;
        stage2_ff <= 1'b0;
      end else begin
        stage1_ff <= pin_level;
        stage2_ff <= stage1_ff;
      end
    end
  end
endgenerate

endmodule // gpiod_sync2

// *** gpiod_cell_sva.sv ***
`timescale 1ns/1ps
module gpiod_cell_sva (
  // clock and reset
  input logic        core_clk,
  input logic        resetn,
  // register bus
  input logic [3:0]  avs_address,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic        avs_waitrequest,
  // core side
  input logic [3:0]  core_out,
  input logic        core_oe,
  input logic [3:0]  core_in,
  input logic        alternate_input_path,
  input logic        core_word_tick,
  // pad side
  input logic        pad_i,
  input logic        pad_o,
  input logic        pad_oe,
  input logic        pad_pull_up,
  input logic        pad_pull_down
);
  logic [14:0] cfg_ff;
  // shadow of control, taken at the completion edge of a write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      cfg_ff <= 15'h0;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h0)
      cfg_ff <= avs_writedata[14:0];
  end
  wire       usr   = cfg_ff[14];
  wire [2:0] md    = cfg_ff[2:0];
  wire       plain = usr && !cfg_ff[9] && !cfg_ff[12];
  wire       in_rr = plain && md == 3'h1 && cfg_ff[3] && !cfg_ff[4];
  wire       out_r = plain && md == 3'h2 && cfg_ff[5] && !cfg_ff[6];
  wire       ser_o = usr && md == 3'h2 && cfg_ff[12] && !cfg_ff[9];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence ser_word;
    ##1 pad_o == $past(core_out[0]) ##1 pad_o == $past(core_out[1], 2)
    ##1 pad_o == $past(core_out[2], 3) ##1 pad_o == $past(core_out[3], 4);
  endsequence
  sequence tick_gap;
    ##1 !core_word_tick [*3] ##1 core_word_tick;
  endsequence
  alt_path_a: assert property (alternate_input_path == pad_i)
    else $error("alt path differs from pad");
  cfg_pull_a: assert property (!usr |-> pad_pull_up && !pad_oe)
    else $error("pull-up missing before user mode");
  unused_pin_a: assert property (usr && md == 3'h0 |-> !pad_oe
    && pad_pull_down == cfg_ff[13] && pad_pull_up == !cfg_ff[13]) else $error("unused pin pull");
  clk_out_a: assert property (usr && md == 3'h4 |-> pad_oe)
    else $error("clock output not driven");
  oe_comb_a: assert property (usr && md == 3'h3 && !cfg_ff[8] |-> pad_oe == core_oe)
    else $error("driver enable differs from core");
  out_comb_a: assert property (plain && md == 3'h2 && !cfg_ff[5] |-> pad_oe && pad_o == core_out[0])
    else $error("direct output wrong");
  out_reg_a: assert property (out_r && $past(out_r) |-> pad_o == ($past(core_out[0]) ^ cfg_ff[7]))
    else $error("registered output wrong");
  in_reg_a: assert property (in_rr && $past(in_rr, 3) |-> core_in[0] == $past(pad_i, 3))
    else $error("registered input wrong");
  ser_out_a: assert property (ser_o && core_word_tick |-> ser_word)
    else $error("serial word order wrong");
  tick_gap_a: assert property (ser_o && core_word_tick |-> tick_gap)
    else $error("word tick spacing wrong");
endmodule // gpiod_cell_sva

// *** gpiod_pad_peer.sv ***
`timescale 1ns/1ps
module gpiod_pad_peer (
  // clock
  input  logic core_clk,
  // pad from the cell
  input  logic pad_o,
  input  logic pad_oe,
  input  logic pad_pull_up,
  input  logic pad_pull_down,
  // bench control
  input  logic drv_en,
  input  logic lvl_high_ph,
  input  logic lvl_low_ph,
  // level seen by the cell
  output logic pad_i
);
  logic drv_lvl = 1'b0;
  logic last_ff = 1'b0;
  // moves 10 ns after each edge, clear of both sampling edges
  always @(posedge core_clk) drv_lvl <= #10 lvl_high_ph;
  always @(negedge core_clk) drv_lvl <= #10 lvl_low_ph;
  always @(posedge core_clk) last_ff <= pad_i;
  // floating and unpulled: inverse of last level, never a kind guess
  assign pad_i = pad_oe ? pad_o : drv_en ? drv_lvl : pad_pull_up ? 1'b1 :
                 pad_pull_down ? 1'b0 : ~last_ff;
endmodule // gpiod_pad_peer

// *** gpiod_io_cell_test.sv ***
`timescale 1ns/1ps
module gpiod_io_cell_test;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, alternate_input_path, core_word_tick;
  logic [3:0]  core_out = 4'h0;
  logic [3:0]  core_in;
  logic        core_oe = 1'b0;
  logic        pad_i, pad_o, pad_oe, pad_pull_up, pad_pull_down, hi, lo;
  logic        drv_en = 1'b0;
  logic        lvl_high_ph = 1'b1;
  logic        lvl_low_ph = 1'b1;
  int          bad_count = 0;
  int          num_checks = 0;
  always #20 core_clk = ~core_clk;
  gpiod_io_cell #(.HS_CELL(1)) dut (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .core_out, .core_oe, .core_in,
    .alternate_input_path, .core_word_tick, .pad_i, .pad_o, .pad_oe, .pad_pull_up,
    .pad_pull_down);
  gpiod_pad_peer peer (.core_clk, .pad_o, .pad_oe, .pad_pull_up, .pad_pull_down, .drv_en,
    .lvl_high_ph, .lvl_low_ph, .pad_i);
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= adr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 16);
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      tally_and_finish();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic phases;
    @(posedge core_clk);
    #10 hi = pad_o;
    @(negedge core_clk);
    #10 lo = pad_o;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(4);
    @(posedge core_clk) resetn <= 1'b1;
    cyc(3);
    chk("pulls", 3'h4, {pad_pull_up, pad_pull_down, pad_oe});
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, 4'h4, 32'h0);
    chk("status", 32'h41, rd);
    bus(1'b1, 4'h0, 32'h6000);
    cyc(1);
    chk("pull down", 3'h2, {pad_pull_up, pad_pull_down, pad_oe});
    $display("test pulls done");
    @(posedge core_clk) drv_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'h0, (i == 2) ? 32'h4009 : (i == 3) ? 32'h4019 : 32'h4001);
      @(posedge core_clk) lvl_high_ph <= i[0];
      lvl_low_ph <= i[0];
      cyc(5);
      chk("input", {i[0], i[0]}, {core_in[0], alternate_input_path});
    end
    @(posedge core_clk) lvl_high_ph <= 1'b0;
    for (int d = 0; d < 3; d++) begin
      bus(1'b1, 4'h0, 32'h4201 | (d << 10));
      cyc(5);
      chk("double_data_io in", 4'h1, core_in);
    end
    $display("test input done");
    @(posedge core_clk) drv_en <= 1'b0;
    core_out <= 4'h1;
    bus(1'b1, 4'h0, 32'h4002);
    cyc(2);
    chk("out direct", 2'h3, {pad_oe, pad_o});
    bus(1'b1, 4'h0, 32'h40A2);
    cyc(2);
    chk("out invert", 2'h2, {pad_oe, pad_o});
    for (int d = 0; d < 3; d++) begin
      bus(1'b1, 4'h0, 32'h4202 | (d << 10));
      cyc(4);
      phases();
      chk("double_data_io out", 2'h2, {hi, lo});
    end
    $display("test output done");
    bus(1'b1, 4'h0, 32'h4003);
    @(posedge core_clk) drv_en <= 1'b1;
    lvl_high_ph <= 1'b1;
    lvl_low_ph <= 1'b1;
    cyc(5);
    chk("bidir hiz", 2'h1, {pad_oe, core_in[0]});
    @(posedge core_clk) drv_en <= 1'b0;
    core_oe <= 1'b1;
    core_out <= 4'h0;
    bus(1'b1, 4'h0, 32'h4023);
    cyc(5);
    chk("bidir drive", 2'h2, {pad_oe, core_in[0]});
    bus(1'b1, 4'h0, 32'h4004);
    phases();
    chk("clock out", 3'h6, {pad_oe, hi, lo});
    $display("test bidir done");
    @(posedge core_clk) core_out <= 4'hB;
    bus(1'b1, 4'h0, 32'h5002);
    cyc(12);
    bus(1'b0, 4'h4, 32'h0);
    chk("serdes on", 1'b1, rd[7]);
    $display("test serdes done");
    tally_and_finish();
  end
endmodule // gpiod_io_cell_test

bind gpiod_io_cell gpiod_cell_sva u_sva (.core_clk, .resetn, .avs_address, .avs_write,
  .avs_writedata, .avs_waitrequest, .core_out, .core_oe, .core_in, .alternate_input_path,
  .core_word_tick, .pad_i, .pad_o, .pad_oe, .pad_pull_up, .pad_pull_down);
